//--- hdl/orv_pkg.sv
// Package for the output reference and overvoltage setup block.
// Assumes a 50 MHz system clock and a classic Wishbone slave port.
package orv_pkg;

  // ==========================================================
  // Bus layout
  localparam int ADR_W = 18;
  localparam int IDX_W = 16;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;
  localparam int REG_W = 8;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } orv_wb_req_t;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REF_HIGH_A = 16'hFE22;
  localparam logic [IDX_W-1:0] IDX_REF_HIGH_B = 16'hFE23;
  localparam logic [IDX_W-1:0] IDX_REF_LOW_A = 16'hFE24;
  localparam logic [IDX_W-1:0] IDX_REF_LOW_B = 16'hFE25;
  localparam logic [IDX_W-1:0] IDX_GUARD_A = 16'hFE26;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 16'hFF00;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hFF01;

  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  // ==========================================================
  // Fields
  localparam int REF_W = 12;
  localparam int LOW_W = 4;
  localparam int THR_W = 6;
  localparam int DEB_LSB = 6;
  localparam int DEB_MSB = 7;
  localparam int IRQ_OVP_BIT = 0;
  localparam int NCH = 2;

  typedef enum logic [1:0] {
    DEB_NONE,
    DEB_SHORT,
    DEB_MID,
    DEB_LONG
  } orv_deb_t;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int DEB_SHORT_NS = 960;
  localparam int DEB_MID_NS = 2240;
  localparam int DEB_LONG_NS = 8000;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] DEB_SHORT_CYC = CNT_W'((DEB_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] DEB_MID_CYC = CNT_W'((DEB_MID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] DEB_LONG_CYC = CNT_W'((DEB_LONG_NS + CLK_NS - 1) / CLK_NS);

endpackage

//--- hdl/orv_top.sv
// Output reference assembly, simple regulation loop and first-channel
// overvoltage guard setup, with a classic Wishbone register slave.
// Assumes ADC results arrive on clk_sys; the comparator output is a pin.
//
// Function
// - First channel reference is its MSB register above low register bits 3:0.
// - Second channel reference is its MSB register above low register bits 3:0.
// - Loop drives each channel until its sense ADC result equals its reference.
// - Overvoltage flag debounce select 00 none, 01 0.96us, 10 2.24us, 11 8us.
// - Six-bit comparator threshold code, 0.75 V plus 11.904 mV per step.
// - Upper eight reference bits come from a separate MSB register per channel.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module orv_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire orv_pkg::orv_wb_req_t wb_req,
  output logic [orv_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [orv_pkg::REF_W-1:0] adc_a,
  input wire logic [orv_pkg::REF_W-1:0] adc_b,
  output logic [orv_pkg::REF_W-1:0] ref_a,
  output logic [orv_pkg::REF_W-1:0] ref_b,
  output logic [orv_pkg::REF_W-1:0] drive_a,
  output logic [orv_pkg::REF_W-1:0] drive_b,
  output logic [orv_pkg::THR_W-1:0] ovp_thr_a,
  input wire logic ovp_cmp_a,
  output logic ovp_flag_a,
  output logic irq
);
  import orv_pkg::*;

  // ==========================================================
  // Bus slave
  logic ack_ff, nxt_ack;
  logic [DAT_W-1:0] rdat_ff, nxt_rdat;
  logic [REG_W-1:0] high_ff [NCH];
  logic [REG_W-1:0] low_ff [NCH];
  logic [REG_W-1:0] ovp_ff, stat_ff, mask_ff;
  logic [REG_W-1:0] nxt_high [NCH];
  logic [REG_W-1:0] nxt_low [NCH];
  logic [REG_W-1:0] nxt_ovp, nxt_stat, nxt_mask;
  logic [IDX_W-1:0] idx;
  logic req, wr;
  logic [REG_W-1:0] wdat;
  logic flag_ff;
  logic flag_rise;

  assign idx = wb_req.adr[ADR_W-1:2];
  // One request per handshake; ack falls the cycle after it rose
  assign req = wb_req.cyc && wb_req.stb && !ack_ff;
  // Write lands at the edge where the master samples ack, never earlier
  assign wr = wb_req.cyc && wb_req.stb && ack_ff && wb_req.we && wb_req.sel[0];
  assign wdat = wb_req.dat[REG_W-1:0];

  always_comb begin
    nxt_ack = req;
    nxt_rdat = rdat_ff;
    nxt_high = high_ff;
    nxt_low = low_ff;
    nxt_ovp = ovp_ff;
    nxt_mask = mask_ff;
    // Set wins over a same-cycle write-one clear
    nxt_stat = stat_ff;
    if (wr && idx == IDX_IRQ_STATUS) begin
      nxt_stat = stat_ff & ~wdat;
    end
    if (flag_rise) begin
      nxt_stat[IRQ_OVP_BIT] = 1'b1;
    end
    if (req) begin
      nxt_rdat = '0;
      case (idx)
        IDX_REF_HIGH_A: nxt_rdat[REG_W-1:0] = high_ff[0];
        IDX_REF_HIGH_B: nxt_rdat[REG_W-1:0] = high_ff[1];
        IDX_REF_LOW_A: nxt_rdat[REG_W-1:0] = low_ff[0];
        IDX_REF_LOW_B: nxt_rdat[REG_W-1:0] = low_ff[1];
        IDX_GUARD_A: nxt_rdat[REG_W-1:0] = ovp_ff;
        IDX_IRQ_STATUS: nxt_rdat[REG_W-1:0] = stat_ff;
        IDX_IRQ_MASK: nxt_rdat[REG_W-1:0] = mask_ff;
        default: nxt_rdat = '0;
      endcase
    end
    if (wr) begin
      case (idx)
        IDX_REF_HIGH_A: nxt_high[0] = wdat;
        IDX_REF_HIGH_B: nxt_high[1] = wdat;
        IDX_REF_LOW_A: nxt_low[0] = wdat;
        IDX_REF_LOW_B: nxt_low[1] = wdat;
        IDX_GUARD_A: nxt_ovp = wdat;
        IDX_IRQ_MASK: nxt_mask = wdat;
        default: nxt_mask = mask_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      high_ff <= '{default: RST_REG};
      low_ff <= '{default: RST_REG};
      ovp_ff <= RST_REG;
      stat_ff <= RST_REG;
      mask_ff <= RST_REG;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      high_ff <= nxt_high;
      low_ff <= nxt_low;
      ovp_ff <= nxt_ovp;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq = |(stat_ff & mask_ff);

  // ==========================================================
  // Reference assembly and regulation
  // Reserved low bits 7:4 are left out of the join on purpose
  logic [REF_W-1:0] ref_w [NCH];
  logic [REF_W-1:0] adc_w [NCH];
  logic [REF_W-1:0] duty_ff [NCH];
  logic [REF_W-1:0] nxt_duty [NCH];

  assign adc_w[0] = adc_a;
  assign adc_w[1] = adc_b;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign ref_w[c] = {high_ff[c], low_ff[c][LOW_W-1:0]};
      // Integrating step of one code per cycle: slow, and overshoots by one code when the sense result lags a cycle
      always_comb begin
        nxt_duty[c] = duty_ff[c];
        if (adc_w[c] < ref_w[c] && duty_ff[c] != '1) begin
          nxt_duty[c] = duty_ff[c] + 1'b1;
        end else if (adc_w[c] > ref_w[c] && duty_ff[c] != '0) begin
          nxt_duty[c] = duty_ff[c] - 1'b1;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          duty_ff[c] <= '0;
        end else begin
          duty_ff[c] <= nxt_duty[c];
        end
      end
    end
  endgenerate

  assign ref_a = ref_w[0];
  assign ref_b = ref_w[1];
  assign drive_a = duty_ff[0];
  assign drive_b = duty_ff[1];

  // ==========================================================
  // Overvoltage guard: threshold and flag debounce
  logic [2:0] sync_ff, nxt_sync;
  logic lvl_ff, nxt_lvl;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt, deb_lim;
  logic nxt_flag;
  orv_deb_t deb_sel;

  assign ovp_thr_a = ovp_ff[THR_W-1:0];
  assign deb_sel = orv_deb_t'(ovp_ff[DEB_MSB:DEB_LSB]);

  always_comb begin
    case (deb_sel)
      DEB_SHORT: deb_lim = DEB_SHORT_CYC;
      DEB_MID: deb_lim = DEB_MID_CYC;
      DEB_LONG: deb_lim = DEB_LONG_CYC;
      default: deb_lim = '0;
    endcase
  end

  always_comb begin
    nxt_sync = {sync_ff[1:0], ovp_cmp_a};
    // Stage one feeds only stage two; level moves when two and three agree
    nxt_lvl = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : lvl_ff;
    nxt_cnt = '0;
    if (lvl_ff) begin
      nxt_cnt = (cnt_ff >= deb_lim) ? deb_lim : cnt_ff + 1'b1;
    end
    nxt_flag = lvl_ff && (nxt_cnt >= deb_lim);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_ff <= '0;
      lvl_ff <= 1'b0;
      cnt_ff <= '0;
      flag_ff <= 1'b0;
    end else begin
      sync_ff <= nxt_sync;
      lvl_ff <= nxt_lvl;
      cnt_ff <= nxt_cnt;
      flag_ff <= nxt_flag;
    end
  end

  assign flag_rise = nxt_flag && !flag_ff;
  assign ovp_flag_a = flag_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ref_a_low: assert property (wr && idx == IDX_REF_LOW_A |=>
    ref_a == {$past(high_ff[0]), $past(wdat[LOW_W-1:0])})
    else $error("first reference low nibble not joined");
  a_ref_b_low: assert property (wr && idx == IDX_REF_LOW_B |=>
    ref_b == {$past(high_ff[1]), $past(wdat[LOW_W-1:0])})
    else $error("second reference low nibble not joined");
  a_ref_high: assert property (wr && idx == IDX_REF_HIGH_A |=>
    ref_a[REF_W-1:LOW_W] == $past(wdat) && low_ff[0] == $past(low_ff[0]))
    else $error("first reference upper bits wrong");
  a_loop_step: assert property (adc_a < ref_a && drive_a != '1 |=>
    drive_a == $past(drive_a) + 1'b1)
    else $error("loop did not raise drive");
  a_loop_hold: assert property (adc_b == ref_b |=> drive_b == $past(drive_b))
    else $error("loop moved at regulation point");
  a_deb_short: assert property (deb_sel == DEB_SHORT && $rose(ovp_flag_a) |->
    cnt_ff == DEB_SHORT_CYC && $past(lvl_ff))
    else $error("short debounce length wrong");
  a_deb_drop: assert property (!lvl_ff |=> !ovp_flag_a)
    else $error("flag stays after comparator low");
  a_thr_code: assert property (wr && idx == IDX_GUARD_A |=>
    ovp_thr_a == $past(wdat[THR_W-1:0]))
    else $error("threshold code not applied");
  a_resv_keep: assert property (wr && idx == IDX_REF_LOW_B |=>
    low_ff[1] == $past(wdat) && ref_b[REF_W-1:LOW_W] == $past(ref_b[REF_W-1:LOW_W]))
    else $error("reserved bits lost or leaked");
  a_irq_set: assert property (flag_rise |=> stat_ff[IRQ_OVP_BIT])
    else $error("overvoltage event lost");

  c_ovp_long: cover property (deb_sel == DEB_LONG && $rose(ovp_flag_a));
  c_irq: cover property ($rose(irq));
  c_reg_a: cover property (adc_a == ref_a && ref_a != '0);
endmodule

`default_nettype wire

//--- tb/orv_top_tb_top.sv
// Self-checking bench for the reference and overvoltage setup block.
// Assumes orv_pkg and orv_top are compiled first; the bench plays the bus
// master, the sense ADCs and the comparator pin.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module orv_top_tb_top;
  import orv_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  orv_wb_req_t wb_req = '0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [REF_W-1:0] adc_a = '0;
  logic [REF_W-1:0] adc_b = '0;
  logic [REF_W-1:0] ref_a, ref_b, drive_a, drive_b;
  logic [THR_W-1:0] ovp_thr_a;
  logic ovp_cmp_a = 1'b0;
  logic ovp_flag_a, irq;
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] rd;
  int cnt [4] = '{0, 48, 112, 400};

  orv_top u_orv_top (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .adc_a(adc_a), .adc_b(adc_b), .ref_a(ref_a), .ref_b(ref_b),
    .drive_a(drive_a), .drive_b(drive_b), .ovp_thr_a(ovp_thr_a), .ovp_cmp_a(ovp_cmp_a),
    .ovp_flag_a(ovp_flag_a), .irq(irq));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Plant: each sense result follows its drive one cycle late, so the loop
  // may settle with a one-code ripple around the reference
  always @(posedge clk_sys) begin
    adc_a <= drive_a;
    adc_b <= drive_b;
  end

  // ==========================================================
  // Bus access, one classic cycle per call
  task automatic bus(input logic we, input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, wd}};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o[7:0];
    if (n >= 50) miscompares++;
    wb_req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bus(1'b0, IDX_REF_LOW_A, 8'h00);
    `CHK("low_a reset", 8'h00, rd)
    bus(1'b0, IDX_GUARD_A, 8'h00);
    `CHK("ovp reset", 8'h00, rd)
    bus(1'b1, IDX_REF_HIGH_A, 8'hA5);
    bus(1'b1, IDX_REF_LOW_A, 8'hF3);
    bus(1'b1, IDX_REF_HIGH_B, 8'h5C);
    bus(1'b1, IDX_REF_LOW_B, 8'h9E);
    `CHK("ref_a", 12'hA53, ref_a)
    `CHK("ref_b", 12'h5CE, ref_b)
    bus(1'b0, IDX_REF_LOW_A, 8'h00);
    `CHK("low_a reserved", 8'hF3, rd)
    bus(1'b0, IDX_REF_LOW_B, 8'h00);
    `CHK("low_b reserved", 8'h9E, rd)
    bus(1'b0, 16'hFF10, 8'h00);
    `CHK("unmapped read", 8'h00, rd)
    // Debounce pulses give the loop only part of its settling time; the 4300-cycle wait below finishes it
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_GUARD_A, {c[1:0], 6'h3F ^ 6'(c)});
      `CHK("threshold", 6'h3F ^ 6'(c), ovp_thr_a)
      bus(1'b1, IDX_IRQ_MASK, {7'h0, c[0]});
      ovp_cmp_a <= 1'b1;
      repeat (cnt[c]) @(posedge clk_sys);
      if (c > 0) `CHK("flag early", 1'b0, ovp_flag_a)
      repeat (12) @(posedge clk_sys);
      `CHK("flag set", 1'b1, ovp_flag_a)
      `CHK("irq masked", c[0], irq)
      ovp_cmp_a <= 1'b0;
      repeat (8) @(posedge clk_sys);
      `CHK("flag clear", 1'b0, ovp_flag_a)
      bus(1'b0, IDX_IRQ_STATUS, 8'h00);
      `CHK("status set", 8'h01, rd)
      bus(1'b1, IDX_IRQ_STATUS, 8'h01);
      bus(1'b0, IDX_IRQ_STATUS, 8'h00);
      `CHK("status clr", 8'h00, rd)
      `CHK("irq low", 1'b0, irq)
    end
    repeat (4300) @(posedge clk_sys);
    `CHK("reg a", 1'b1, (12'(adc_a - ref_a + 12'h001) <= 12'h002))
    `CHK("reg b", 1'b1, (12'(adc_b - ref_b + 12'h001) <= 12'h002))
    report_and_stop();
  end
endmodule

`default_nettype wire
